// ### nbs_checker.sv
// Checker for the nine-bit serial port: bus answers and transmit framing.
// Assumes the bit divisor is set to BIT_CYC clocks before any transmission.
`timescale 1ns/1ps
module nbs_checker #(
   parameter int BIT_CYC = 4 // Clocks per bit used by the bench
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic [4:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic [4:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        txd,
   input wire logic        irq
);
   logic [5:0] cnt;    // Cycles into the current transmit frame
   logic       tx_on;  // Transmit frame in progress
   logic       aw_buf; // Last write address was the serial buffer
   // Follow the frame position on the line itself
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_on  <= 1'b0;
         cnt    <= 6'h00;
         aw_buf <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) aw_buf <= (s_axi_awaddr == 5'h00);
         if (!tx_on && !txd) begin
            tx_on <= 1'b1;
            cnt   <= 6'h01;
         end else if (tx_on) begin
            tx_on <= (cnt != 6'(11 * BIT_CYC - 1));
            cnt   <= cnt + 6'h01;
         end
      end
   end
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_start; !txd [*4]; endsequence
   sequence s_went; $rose(s_axi_bvalid) && aw_buf && !tx_on; endsequence
   property p_start; $fell(txd) && !tx_on |-> s_start; endproperty
   property p_bit; tx_on && (cnt % BIT_CYC != 0) |-> $stable(txd); endproperty
   property p_stop; tx_on && cnt >= 6'(10 * BIT_CYC) |-> txd; endproperty
   property p_done; tx_on && cnt == 6'(10 * BIT_CYC) |-> irq; endproperty
   property p_go; s_went |-> ##[0:2] !txd; endproperty
   property p_rst; $rose(aresetn) |-> txd && !irq && !s_axi_bvalid && !s_axi_rvalid; endproperty
   property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr[4:2] > 3'd4 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
   endproperty
   a_start: assert property (p_start) else $error("start bit too short");
   a_bit: assert property (p_bit) else $error("bit changed mid period");
   a_stop: assert property (p_stop) else $error("stop bit not high");
   a_done: assert property (p_done) else $error("no irq at stop start");
   a_go: assert property (p_go) else $error("buffer write sent nothing");
   a_rst: assert property (p_rst) else $error("bad state after reset");
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule // nbs_checker
bind nbs_serial_port nbs_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp,
   .s_axi_rdata, .txd, .irq);

// ### nbs_map.vh
// Constants for the nine-bit serial port: register offsets, field positions, timing.
// Assumes a 20 MHz aclk and an AXI4-Lite master with 32-bit data.
// Behaviour
// - Frame is start, eight data LSB-first, ninth, stop
// - Transmit ninth bit from control bit 3
// - Received ninth bit to control bit 2; stop unchecked
// - Writing serial buffer while idle starts a transmission
// - Transmit done set at stop-bit start
// - Reception starts only while receive enable bit 4 set
// - Accept only if rx done clear, ninth-bit check
// - Accepted frame loads buffer, ninth bit, rx done
// - Rejected frame leaves buffer and flags untouched
// - Interrupt when either done flag becomes set
// - Multiproc check: interrupt only for ninth-bit-one frames
`ifndef NBS_MAP_VH
`define NBS_MAP_VH
// Register byte offsets
`define NBS_OFF_BUFFER    5'h00
`define NBS_OFF_CONTROL   5'h04
`define NBS_OFF_STATUS    5'h08
`define NBS_OFF_MASK      5'h0c
`define NBS_OFF_DIVISOR   5'h10
// Control field positions
`define NBS_CTL_TXDONE    1
`define NBS_CTL_RXDONE    0
`define NBS_CTL_RXNINTH   2
`define NBS_CTL_TXNINTH   3
`define NBS_CTL_RXEN      4
`define NBS_CTL_MCE       5
// Status bits: 0 rx event, 1 tx event
`define NBS_ST_RX         0
`define NBS_ST_TX         1
// Bit-period divisor reset value (clocks per bit, 20 MHz / 173 ~ 115200)
`define NBS_DIV_RESET     16'h00ad
// Bits after start: 8 data + ninth
`define NBS_DATA_BITS     4'h9
`endif

// ### nbs_remote.sv
// Remote nine-bit serial port: sends frames on rxd, captures frames from txd.
// Assumes the device bit period equals DIV aclk cycles.
`timescale 1ns/1ps
module nbs_remote #(
   parameter int DIV = 4 // Clocks per bit
) (
   input  wire logic aclk,
   input  wire logic txd,
   output logic      rxd
);
   logic [9:0] got_q[$]; // Captured {stop, ninth, data}
   logic [9:0] f;        // Frame being captured
   initial rxd = 1'b1; // Line idles high
   // Start low, data LSB first, ninth, stop high
   task automatic send(input logic [7:0] d, input logic n);
      logic [10:0] fr;
      fr = {1'b1, n, d, 1'b0};
      for (int i = 0; i < 11; i++) begin
         rxd <= fr[i];
         repeat (DIV) @(posedge aclk);
      end
   endtask
   // Sample each bit of the device frame after the start bit at mid-bit
   always begin
      @(negedge txd);
      repeat (DIV / 2) @(posedge aclk);
      for (int i = 0; i < 10; i++) begin
         repeat (DIV) @(posedge aclk);
         f[i] = txd;
      end
      got_q.push_back(f);
   end
endmodule // nbs_remote

// ### nbs_serial_port.v
// Nine-bit asynchronous serial port with multiprocessor address filtering.
// Registers: serial buffer, control, interrupt status, interrupt mask, bit divisor.
// Assumes rxd is already synchronous to aclk and an AXI4-Lite master.
// Assumes the far end runs at the same bit period; no rate tolerance is built in.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "nbs_map.vh"
module nbs_serial_port (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [4:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [4:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        rxd,
   output reg         txd,
   output wire        irq
);
   // Software-visible state
   reg  [7:0]  serial_buffer;        // Receive buffer
   reg  [5:0]  serial_control_reg;   // Control and flag bits
   // Events stay set until cleared; the mask only gates the pin
   reg  [1:0]  irq_status;           // Sticky events
   reg  [1:0]  irq_mask;             // Interrupt enables
   reg  [15:0] bit_div;              // Clocks per bit
   // Write channel capture
   reg  [4:0]  aw_addr;
   reg         aw_held;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_held;
   // Transmitter; counters hold clocks left in the current bit, zero marks its end
   // Bit counters count the bits left after the start bit down to one
   reg  [1:0]  tx_state;
   reg  [15:0] tx_cnt;
   reg  [3:0]  tx_bits;
   reg  [8:0]  tx_shift;
   // Receiver
   reg  [1:0]  rx_state;
   reg  [15:0] rx_cnt;
   reg  [3:0]  rx_bits;
   reg  [8:0]  rx_shift;
   // State codes shared by the transmit and receive machines
   localparam ST_IDLE  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_DATA  = 2'd2;
   localparam ST_STOP  = 2'd3;

   // Channel readiness: take each write half while not already held
   // A new half is refused while the response is pending, so a second write
   // can never overwrite a captured half before it has executed
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // Register decode of a captured write; byte lane 0 gates the byte-wide
   // registers, the divisor is taken whole regardless of strobes
   // Unmapped writes still answer, with an error code, and change nothing
   wire do_write  = aw_held && w_held && !s_axi_bvalid;          // Both halves present
   wire wr_buffer = do_write && aw_addr[4:2] == 3'd0 && w_strb[0];
   wire wr_ctl    = do_write && aw_addr[4:2] == 3'd1 && w_strb[0];
   wire wr_stat   = do_write && aw_addr[4:2] == 3'd2 && w_strb[0];
   wire wr_mask   = do_write && aw_addr[4:2] == 3'd3 && w_strb[0];
   wire wr_div    = do_write && aw_addr[4:2] == 3'd4;
   wire wr_mapped = aw_addr[4:2] <= 3'd4;

   // Transmit and receive events from the state machines
   // The transmit event marks the edge on which the stop bit goes out
   wire tx_stop_start = tx_state == ST_DATA && tx_cnt == 16'h0000 && tx_bits == 4'h1;
   wire rx_sample     = rx_cnt == 16'h0000;
   // First look at the start bit comes half a period after the falling edge, which
   // puts every later sample in mid-bit; a divisor below two samples at once
   wire [15:0] rx_half = (bit_div[15:1] == 15'h0000) ? 16'h0000 :
                         {1'b0, bit_div[15:1]} - 16'h0001;
   wire rx_frame_end  = rx_state == ST_STOP && rx_sample;
   // A rejected frame drops here; nothing below is touched
   wire rx_accept     = rx_frame_end && !serial_control_reg[`NBS_CTL_RXDONE] &&
                        (!serial_control_reg[`NBS_CTL_MCE] || rx_shift[8]);

   // Interrupt is high while any unmasked sticky event is set
   // Clearing a mask bit hides an event without losing it
   assign irq = |(irq_status & irq_mask);

   // Write address and data capture, response generation
   // The response is registered, so it follows the later half by two cycles
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 5'h00;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else begin
         // Hold each half until both are here
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         // Both halves held: execute the write and raise the response
         if (do_write) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? 2'b00 : 2'b10;   // Unmapped answers SLVERR
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: one-cycle latency from address acceptance
   // The address is decoded at the handshake, so it need not stand any longer
   // A read of an unmapped word returns zero with an error code
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= 2'b00;
         case (s_axi_araddr[4:2])
            3'd0:    s_axi_rdata <= {24'h000000, serial_buffer};
            3'd1:    s_axi_rdata <= {26'h0, serial_control_reg};
            3'd2:    s_axi_rdata <= {30'h0, irq_status};
            3'd3:    s_axi_rdata <= {30'h0, irq_mask};
            3'd4:    s_axi_rdata <= {16'h0000, bit_div};
            default: begin
               s_axi_rdata <= 32'h00000000;
               s_axi_rresp <= 2'b10;                      // Unmapped answers SLVERR
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Control register, buffer, sticky status and mask; hardware sets win over clears
   // Order matters: software writes come first so that a hardware set in the
   // same cycle lands on top of them
   always @(posedge aclk) begin
      if (!aresetn) begin
         serial_control_reg <= 6'h00;
         serial_buffer      <= 8'h00;
         irq_status         <= 2'b00;
         irq_mask           <= 2'b00;
         bit_div            <= `NBS_DIV_RESET;
      end else begin
         // Plain software writes; control flags are cleared by writing them as zero, status bits by writing one
         if (wr_ctl)
            serial_control_reg <= w_data[5:0];
         if (wr_mask)
            irq_mask <= w_data[1:0];
         if (wr_div)
            bit_div <= w_data[15:0];
         if (wr_stat)
            irq_status <= irq_status & ~w_data[1:0];       // Write one to clear
         // Transmit done at the start of the stop bit
         if (tx_stop_start) begin
            serial_control_reg[`NBS_CTL_TXDONE] <= 1'b1;
            irq_status[`NBS_ST_TX]             <= 1'b1;
         end
         // Accepted frame loads data, ninth bit and done flag; rejected leaves all alone
         if (rx_accept) begin
            serial_buffer                        <= rx_shift[7:0];
            serial_control_reg[`NBS_CTL_RXNINTH] <= rx_shift[8];
            serial_control_reg[`NBS_CTL_RXDONE]  <= 1'b1;
            irq_status[`NBS_ST_RX]              <= 1'b1;
         end
      end
   end

   // Transmitter: start low, nine bits LSB first, stop high
   // A buffer write while a frame is under way is dropped without notice;
   // software must wait out the stop bit after the done flag before the next byte
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_state <= ST_IDLE;
         tx_cnt   <= 16'h0000;
         tx_bits  <= 4'h0;
         tx_shift <= 9'h000;
         // Line idles high from reset on
         txd      <= 1'b1;
      end else begin
         case (tx_state)
            ST_IDLE: begin
               txd <= 1'b1;
               // The ninth bit is the control bit as it stands at the write
               if (wr_buffer) begin
                  tx_shift <= {serial_control_reg[`NBS_CTL_TXNINTH], w_data[7:0]};
                  tx_state <= ST_START;
                  tx_cnt   <= bit_div - 16'h0001;
                  txd      <= 1'b0;
               end
            end
            ST_START: begin
               // End of start bit: data bit 0 goes out, the ninth bit sits in bit 8
               if (tx_cnt == 16'h0000) begin
                  tx_state <= ST_DATA;
                  tx_cnt   <= bit_div - 16'h0001;
                  tx_bits  <= `NBS_DATA_BITS;
                  txd      <= tx_shift[0];
                  tx_shift <= {1'b0, tx_shift[8:1]};
               end else begin
                  tx_cnt <= tx_cnt - 16'h0001;
               end
            end
            ST_DATA: begin
               if (tx_cnt == 16'h0000) begin
                  tx_cnt <= bit_div - 16'h0001;
                  // Ninth bit just finished: stop bit follows
                  if (tx_bits == 4'h1) begin
                     tx_state <= ST_STOP;
                     txd      <= 1'b1;
                  end else begin
                     tx_bits  <= tx_bits - 4'h1;
                     txd      <= tx_shift[0];
                     tx_shift <= {1'b0, tx_shift[8:1]};
                  end
               end else begin
                  tx_cnt <= tx_cnt - 16'h0001;
               end
            end
            ST_STOP: begin
               // Line stays high one full period before the next start may begin
               if (tx_cnt == 16'h0000)
                  tx_state <= ST_IDLE;
               else
                  tx_cnt <= tx_cnt - 16'h0001;
            end
            default: tx_state <= ST_IDLE;
         endcase
      end
   end

   // Receiver: samples each bit mid-period; stop value is never checked
   // The ninth bit ends in bit 8 of the shifter, the first data bit in bit 0
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_state <= ST_IDLE;
         rx_cnt   <= 16'h0000;
         rx_bits  <= 4'h0;
         rx_shift <= 9'h000;
      end else begin
         // Count down in every busy state; each sample that does not end the frame reloads below
         if (rx_state != ST_IDLE && !rx_sample)
            rx_cnt <= rx_cnt - 16'h0001;
         case (rx_state)
            ST_IDLE: begin
               // Falling edge only seen while enabled
               if (serial_control_reg[`NBS_CTL_RXEN] && !rxd) begin
                  rx_state <= ST_START;
                  rx_cnt   <= rx_half;
               end
            end
            ST_START: begin
               if (rx_sample) begin
                  if (rxd) begin
                     // Line high again at the first look: a glitch, not a start bit
                     rx_state <= ST_IDLE;                   // False start
                  end else begin
                     rx_state <= ST_DATA;
                     rx_bits  <= `NBS_DATA_BITS;
                     rx_cnt   <= bit_div - 16'h0001;
                  end
               end
            end
            ST_DATA: begin
               if (rx_sample) begin
                  // Nine samples: eight data bits, then the ninth
                  rx_shift <= {rxd, rx_shift[8:1]};
                  rx_cnt   <= bit_div - 16'h0001;
                  rx_bits  <= rx_bits - 4'h1;
                  if (rx_bits == 4'h1)
                     rx_state <= ST_STOP;
               end
            end
            ST_STOP: begin
               // Frame ends at the middle of the stop bit; its value is not looked at
               if (rx_sample)
                  rx_state <= ST_IDLE;
            end
            default: rx_state <= ST_IDLE;
         endcase
      end
   end
endmodule // nbs_serial_port

// ### tb.sv
// Self-checking bench for the nine-bit serial port with a remote partner.
// Assumes the design, its map header, the checker and nbs_remote compile first.
`timescale 1ns/1ps
`include "nbs_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
   $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb;
   logic        aclk = 0, aresetn = 0, rxd, txd, irq;
   logic [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int          fail_count = 0, cmp_count = 0, m_ctl = 0, m_st = 0, m_buf = 0, m_msk = 0, t;
   logic [7:0]  d;
   logic [9:0]  frm;   // Frame taken from the partner
   // Receive cases: {control written, ninth bit}
   logic [6:0]  tab [6] = '{7'h01, 7'h20, 7'h23, 7'h60, 7'h61, 7'h20};
   nbs_serial_port u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd, .txd, .irq);
   nbs_remote #(.DIV(4)) u_rem (.aclk, .txd, .rxd);
   initial forever #25 aclk = ~aclk;
   // Verdict and end of run
   task automatic stop_test;
      if (fail_count == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // A wait that ran out counts as a mismatch
   task automatic give_up;
      fail_count++;
      stop_test();
   endtask
   // Bus write, address and data offered together
   task automatic wr(input logic [4:0] a, input logic [31:0] v);
      int k;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      if (k == 20) give_up();
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   // Bus read
   task automatic rd(input logic [4:0] a);
      int k;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      if (k == 20) give_up();
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   // Reference receiver: acceptance and loading of a frame
   task automatic mdl_rx(input int v, input int n);
      if ((m_ctl & 'h10) != 0 && (m_ctl & 1) == 0 && (n != 0 || (m_ctl & 'h20) == 0)) begin
         m_buf = v;
         m_ctl = (m_ctl & ~4) | 1 | (n << 2);
         m_st |= 1;
      end
   endtask
   // Compare registers and interrupt with the reference
   task automatic chk_regs;
      rd(`NBS_OFF_CONTROL);
      `CHK(rdat, 32'(m_ctl))
      rd(`NBS_OFF_STATUS);
      `CHK(rdat, 32'(m_st))
      rd(`NBS_OFF_BUFFER);
      `CHK(rdat, 32'(m_buf))
      `CHK(irq, |(m_st & m_msk))
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      d = 8'($urandom(17));
      rd(`NBS_OFF_DIVISOR);
      `CHK(rdat, 32'(`NBS_DIV_RESET))
      chk_regs();
      rd(5'h14);
      `CHK({resp, rdat}, {2'b10, 32'h0})
      wr(5'h14, 32'h1);
      `CHK(resp, 2'b10)
      wr(`NBS_OFF_DIVISOR, 32'h4);
      m_msk = 3;
      wr(`NBS_OFF_MASK, 32'h3);
      // Transmit once with each ninth-bit value
      for (int n = 0; n < 2; n++) begin
         d = 8'($urandom);
         m_ctl = n << 3;
         wr(`NBS_OFF_CONTROL, 32'(m_ctl));
         wr(`NBS_OFF_BUFFER, {24'h0, d});
         for (t = 0; t < 100 && u_rem.got_q.size() == 0; t++) @(posedge aclk);
         if (t == 100) give_up();
         frm = u_rem.got_q.pop_front();
         `CHK(frm, {1'b1, 1'(n), d})
         m_ctl |= 2;
         m_st |= 2;
         chk_regs();
         wr(`NBS_OFF_STATUS, 32'h2);
         m_st = 0;
      end
      // Receive: disabled, accepted, flag still set, address filtering
      foreach (tab[i]) begin
         d = 8'($urandom);
         m_ctl = int'(tab[i][6:1]);
         wr(`NBS_OFF_CONTROL, 32'(m_ctl));
         u_rem.send(d, tab[i][0]);
         mdl_rx(d, int'(tab[i][0]));
         chk_regs();
      end
      m_msk = 2;
      wr(`NBS_OFF_MASK, 32'h2);
      `CHK(irq, 1'b0)
      wr(`NBS_OFF_STATUS, 32'h1);
      m_st = 0;
      chk_regs();
      stop_test();
   end
endmodule // tb
